// ===== rtl/echo_buffer.sv
// Purpose: byte store for received command characters
// Assumes: one write and one read port on the same clock
// Notes: read data is registered, one cycle after the address
`timescale 1ns/1ps
module echo_buffer (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // write side
    input wire logic wrEn,
    input wire logic [meter_cmd_pkg::MEM_AW-1:0] wrAddr,
    input wire logic [7:0] wrData,
    // read side
    input wire logic [meter_cmd_pkg::MEM_AW-1:0] rdAddr,
    output logic [7:0] rdData
);
    import meter_cmd_pkg::*;
    logic [7:0] mem [0:MEM_DEPTH-1];

    // array has no reset, stale bytes are never read past the frame length
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read port
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData <= 8'h00;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

// ===== rtl/meter_cmd_pkg.sv
// Purpose: shared constants for the panel meter command handler
// Assumes: frames arrive as ASCII characters with framing already stripped
// Notes: two-character fields are held as pairs of ASCII bytes
package meter_cmd_pkg;
    // main and sub request codes, as four ASCII characters
    localparam logic [31:0] CMD_OPER = 32'h3330_3035;
    localparam logic [31:0] CMD_ATTR = 32'h3035_3033;
    localparam logic [31:0] CMD_STAT = 32'h3036_3031;
    localparam logic [31:0] CMD_READ = 32'h3031_3031;
    localparam logic [31:0] CMD_ECHO = 32'h3038_3031;
    // instruction codes and related information
    localparam logic [15:0] INS_WRITE = 16'h3030;
    localparam logic [15:0] INS_AREA2 = 16'h3037;
    localparam logic [15:0] INS_PROTECT = 16'h3038;
    localparam logic [15:0] REL_00 = 16'h3030;
    localparam logic [15:0] REL_01 = 16'h3031;
    // readonly_variable_type read of address 0000, bit 00, one element
    localparam logic [95:0] VER_ARGS = 96'h4330_3030_3030_3030_3030_3031;
    // response codes
    localparam logic [15:0] RC_OK = 16'h0000;
    localparam logic [15:0] RC_TOO_LONG = 16'h1001;
    localparam logic [15:0] RC_NVM_FAULT = 16'h2203;
    localparam logic [15:0] RC_REJECT = 16'h2203;
    localparam logic [15:0] RC_UNSUP = 16'h0401;
    // frame lengths in characters
    localparam logic [7:0] LEN_HDR = 8'h04;
    localparam logic [7:0] LEN_OPER = 8'h08;
    localparam logic [7:0] LEN_VER = 8'h10;
    localparam logic [7:0] LEN_ECHO_MAX = 8'h5B;
    localparam logic [7:0] LEN_RESP_BASE = 8'h08;
    localparam logic [7:0] LEN_ATTR_DATA = 8'h0E;
    localparam logic [7:0] LEN_STAT_DATA = 8'h04;
    localparam logic [7:0] LEN_VER_DATA = 8'h08;
    // attribute fields
    localparam logic [15:0] BUF_SIZE_CODE = 16'h0068;
    localparam logic [7:0] MODEL_FIELD = 8'h0A;
    localparam logic [7:0] BLANK = 8'h20;
    // model name is arbitrary, left aligned, MODEL_LEN bytes used
    localparam logic [79:0] MODEL_NAME = 80'h504D_2D44_454D_4F00_0000;
    localparam logic [7:0] MODEL_LEN = 8'h07;
    localparam logic [31:0] VERSION = 32'h0000_0100;
    // lockout value that forbids the move to the second area
    localparam logic [1:0] LOCK_NO_INIT = 2'h2;
    // related information reported as unknown
    localparam logic [7:0] REL_UNKNOWN = 8'hFF;
    // receive store
    localparam int MEM_DEPTH = 128;
    localparam int MEM_AW = 7;
    localparam logic [7:0] MEM_LIMIT = 8'h80;
    typedef enum logic [2:0] {K_OPER, K_ATTR, K_STAT, K_VER, K_ECHO, K_BAD} kind_t;
    typedef enum logic [2:0] {S_RECV, S_EXEC, S_FETCH, S_LOAD, S_WAIT} state_t;
endpackage

// ===== rtl/panel_meter_command_handler.sv
// Purpose: decodes host link frames and builds the response character stream
// Assumes: framing stripped upstream; all inputs come from logic on clk
// Notes: one frame is handled at a time, reception stalls while answering
`timescale 1ns/1ps
module panel_meter_command_handler (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // command characters
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxLast,
    output logic rxReady,
    // response characters
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txReady,
    // meter state
    input wire logic [1:0] initLockout,
    input wire logic nvmFault,
    input wire logic measureSuspended,
    input wire logic noMeasuredValue,
    input wire logic inputAnomaly,
    input wire logic displayRangeOver,
    input wire logic [7:0] relatedInfo,
    // mode outputs
    output logic areaSecond,
    output logic protectLevel,
    output logic writeEnable
);
    import meter_cmd_pkg::*;
    state_t state_r;
    kind_t kind_r, kindNxt;
    logic [7:0] hdr_r [0:15];
    logic [7:0] rxCount_r, idx_r, respLen_r, respLenNxt, d;
    logic [15:0] rc_r, rcNxt, rcSh;
    logic [31:0] cmd, verSh;
    logic [15:0] ins, rel, bufSh;
    logic [79:0] nameSh;
    logic moveArea, moveProt, setWr, wrVal, opStat_r, sendLast;
    logic [7:0] relInfo_r, charNext, memRd;
    logic [MEM_AW-1:0] rdAddr;
    logic memWr;

    function automatic logic [7:0] hexChar(input logic [3:0] n);
        return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    assign memWr = rxValid && rxReady && (rxCount_r < MEM_LIMIT);
    assign rdAddr = idx_r[MEM_AW-1:0] - 7'h04; // echo data sits after the header
    assign sendLast = (idx_r == respLen_r - 8'h01);

    echo_buffer u_buf (
        .clk(clk),
        .reset(reset),
        .wrEn(memWr),
        .wrAddr(rxCount_r[MEM_AW-1:0]),
        .wrData(rxData),
        .rdAddr(rdAddr),
        .rdData(memRd)
    );

    // header capture and length count; count saturates so long frames stay long
    always_ff @(posedge clk) begin
        if (reset) begin
            rxCount_r <= 8'h00;
            for (int i = 0; i < 16; i++) begin
                hdr_r[i] <= 8'h00;
            end
        end else if (rxValid && rxReady) begin
            if (rxCount_r < 8'h10) begin
                hdr_r[rxCount_r[3:0]] <= rxData;
            end
            if (rxCount_r != 8'hFF) begin
                rxCount_r <= rxCount_r + 8'h01;
            end
        end else if (state_r == S_WAIT && txReady && sendLast) begin
            rxCount_r <= 8'h00;
        end
    end

    // decode of a complete frame
    always_comb begin
        cmd = {hdr_r[0], hdr_r[1], hdr_r[2], hdr_r[3]};
        ins = {hdr_r[4], hdr_r[5]};
        rel = {hdr_r[6], hdr_r[7]};
        kindNxt = K_BAD;
        rcNxt = RC_UNSUP;
        moveArea = 1'b0;
        moveProt = 1'b0;
        setWr = 1'b0;
        wrVal = (rel == REL_01);
        if (rxCount_r >= LEN_HDR) begin
            case (cmd)
                CMD_OPER: begin
                    kindNxt = K_OPER;
                    if (rxCount_r > LEN_OPER) begin
                        rcNxt = RC_TOO_LONG;
                    end else if (rxCount_r < LEN_OPER) begin
                        rcNxt = RC_UNSUP;
                    end else if (ins == INS_WRITE && (rel == REL_00 || rel == REL_01)) begin
                        setWr = 1'b1;
                        rcNxt = RC_OK;
                    end else if (ins == INS_AREA2 && rel == REL_00) begin
                        if (!writeEnable) begin
                            rcNxt = RC_REJECT;
                        end else if (areaSecond) begin
                            rcNxt = RC_OK;
                        end else if (initLockout == LOCK_NO_INIT) begin
                            rcNxt = RC_REJECT;
                        end else begin
                            moveArea = 1'b1;
                            rcNxt = RC_OK;
                        end
                    end else if (ins == INS_PROTECT && rel == REL_00) begin
                        if (!writeEnable) begin
                            rcNxt = RC_REJECT;
                        end else if (areaSecond) begin
                            rcNxt = RC_REJECT;
                        end else begin
                            moveProt = 1'b1;
                            rcNxt = RC_OK;
                        end
                    end
                end
                CMD_ATTR, CMD_STAT: begin
                    kindNxt = (cmd == CMD_ATTR) ? K_ATTR : K_STAT;
                    rcNxt = (rxCount_r > LEN_HDR) ? RC_TOO_LONG : (nvmFault ? RC_NVM_FAULT : RC_OK);
                end
                CMD_READ: begin
                    if (rxCount_r > LEN_VER) begin
                        kindNxt = K_VER;
                        rcNxt = RC_TOO_LONG;
                    end else if (rxCount_r == LEN_VER &&
                                 {ins, rel, hdr_r[8], hdr_r[9], hdr_r[10], hdr_r[11],
                                  hdr_r[12], hdr_r[13], hdr_r[14], hdr_r[15]} == VER_ARGS) begin
                        kindNxt = K_VER;
                        rcNxt = RC_OK;
                    end
                end
                CMD_ECHO: begin
                    kindNxt = K_ECHO;
                    rcNxt = (rxCount_r > LEN_ECHO_MAX) ? RC_TOO_LONG : (nvmFault ? RC_NVM_FAULT : RC_OK);
                end
                default: begin
                    kindNxt = K_BAD;
                end
            endcase
        end
        respLenNxt = LEN_RESP_BASE;
        if (rcNxt == RC_OK) begin
            case (kindNxt)
                K_ATTR: respLenNxt = LEN_RESP_BASE + LEN_ATTR_DATA;
                K_STAT: respLenNxt = LEN_RESP_BASE + LEN_STAT_DATA;
                K_VER: respLenNxt = LEN_RESP_BASE + LEN_VER_DATA;
                K_ECHO: respLenNxt = LEN_RESP_BASE + rxCount_r - LEN_HDR;
                default: respLenNxt = LEN_RESP_BASE;
            endcase
        end
    end

    // setting area, protect level and write permission
    always_ff @(posedge clk) begin
        if (reset) begin
            areaSecond <= 1'b0;
            protectLevel <= 1'b0;
            writeEnable <= 1'b0;
        end else if (state_r == S_EXEC) begin
            if (moveArea) begin
                areaSecond <= 1'b1;
                protectLevel <= 1'b0;
            end
            if (moveProt) begin
                protectLevel <= 1'b1;
            end
            if (setWr) begin
                writeEnable <= wrVal;
            end
        end
    end

    // answer fields frozen at decode so the stream stays consistent
    always_ff @(posedge clk) begin
        if (reset) begin
            kind_r <= K_BAD;
            rc_r <= RC_OK;
            respLen_r <= LEN_RESP_BASE;
            opStat_r <= 1'b0;
            relInfo_r <= 8'h00;
        end else if (state_r == S_EXEC) begin
            kind_r <= kindNxt;
            rc_r <= rcNxt;
            respLen_r <= respLenNxt;
            opStat_r <= measureSuspended || noMeasuredValue || inputAnomaly || displayRangeOver;
            relInfo_r <= areaSecond ? REL_UNKNOWN : relatedInfo;
        end
    end

    // character for the current response position
    always_comb begin
        d = idx_r - LEN_RESP_BASE;
        rcSh = rc_r << {idx_r[1:0], 2'b00};
        verSh = VERSION << {d[2:0], 2'b00};
        nameSh = MODEL_NAME << {d[3:0], 3'b000};
        bufSh = BUF_SIZE_CODE << {d[1:0] - 2'h2, 2'b00};
        charNext = BLANK;
        if (idx_r < LEN_HDR) begin
            charNext = hdr_r[idx_r[1:0]];
        end else if (idx_r < LEN_RESP_BASE) begin
            charNext = hexChar(rcSh[15:12]);
        end else begin
            case (kind_r)
                K_ATTR: begin
                    if (d < MODEL_FIELD) begin
                        charNext = (d < MODEL_LEN) ? nameSh[79:72] : BLANK;
                    end else begin
                        charNext = hexChar(bufSh[15:12]);
                    end
                end
                K_STAT: begin
                    case (d[1:0])
                        2'h0: charNext = 8'h30;
                        2'h1: charNext = opStat_r ? 8'h31 : 8'h30;
                        2'h2: charNext = hexChar(relInfo_r[7:4]);
                        default: charNext = hexChar(relInfo_r[3:0]);
                    endcase
                end
                K_VER: charNext = hexChar(verSh[31:28]);
                K_ECHO: charNext = memRd;
                default: charNext = BLANK;
            endcase
        end
    end

    // sequencing: one fetch cycle per character lets the buffer read settle
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= S_RECV;
            rxReady <= 1'b1;
            idx_r <= 8'h00;
            txValid <= 1'b0;
            txData <= 8'h00;
            txLast <= 1'b0;
        end else begin
            case (state_r)
                S_RECV: begin
                    if (rxValid && rxReady && rxLast) begin
                        rxReady <= 1'b0;
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    idx_r <= 8'h00;
                    state_r <= S_FETCH;
                end
                S_FETCH: state_r <= S_LOAD;
                S_LOAD: begin
                    txValid <= 1'b1;
                    txData <= charNext;
                    txLast <= sendLast;
                    state_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (txReady) begin
                        txValid <= 1'b0;
                        txLast <= 1'b0;
                        if (sendLast) begin
                            rxReady <= 1'b1;
                            state_r <= S_RECV;
                        end else begin
                            idx_r <= idx_r + 8'h01;
                            state_r <= S_FETCH;
                        end
                    end
                end
                default: state_r <= S_RECV;
            endcase
        end
    end

    // checks
    sequence s_exec_to_first;
        (state_r == S_EXEC) ##3 txValid;
    endsequence
    property p_first_char;
        @(posedge clk) disable iff (reset) (state_r == S_EXEC) |-> s_exec_to_first ##0 (txData == hdr_r[0]);
    endproperty
    a_first_char: assert property (p_first_char) else $error("response does not open with header");
    property p_reset_area;
        @(posedge clk) reset |=> !areaSecond && !protectLevel;
    endproperty
    a_reset_area: assert property (p_reset_area) else $error("not in first area after reset");
    property p_move_area;
        @(posedge clk) disable iff (reset)
            (state_r == S_EXEC && moveArea) |=> areaSecond && rc_r == RC_OK;
    endproperty
    a_move_area: assert property (p_move_area) else $error("area move not taken");
    property p_ignore_area;
        @(posedge clk) disable iff (reset)
            (state_r == S_EXEC && kindNxt == K_OPER && ins == INS_AREA2 && writeEnable && areaSecond
             && rxCount_r == LEN_OPER && rel == REL_00) |=> areaSecond && rc_r == RC_OK;
    endproperty
    a_ignore_area: assert property (p_ignore_area) else $error("repeat area move not ignored");
    property p_lockout;
        @(posedge clk) disable iff (reset)
            (state_r == S_EXEC && cmd == CMD_OPER && ins == INS_AREA2 && rel == REL_00 && writeEnable
             && !areaSecond && initLockout == LOCK_NO_INIT && rxCount_r == LEN_OPER)
            |=> !areaSecond && rc_r == RC_REJECT;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout did not reject area move");
    property p_protect_err;
        @(posedge clk) disable iff (reset)
            (state_r == S_EXEC && cmd == CMD_OPER && ins == INS_PROTECT && areaSecond)
            |=> rc_r != RC_OK && $stable(protectLevel);
    endproperty
    a_protect_err: assert property (p_protect_err) else $error("protect move accepted in second area");
    property p_write_off;
        @(posedge clk) disable iff (reset)
            (state_r == S_EXEC && cmd == CMD_OPER && !writeEnable && ins != INS_WRITE)
            |=> $stable(areaSecond) && $stable(protectLevel) && rc_r != RC_OK;
    endproperty
    a_write_off: assert property (p_write_off) else $error("instruction taken with writing off");
    property p_buf_size;
        @(posedge clk) disable iff (reset)
            (txValid && kind_r == K_ATTR && rc_r == RC_OK && idx_r == 8'h14) |-> txData == 8'h36;
    endproperty
    a_buf_size: assert property (p_buf_size) else $error("buffer size digit wrong");
    property p_pad;
        @(posedge clk) disable iff (reset)
            (txValid && kind_r == K_ATTR && idx_r >= 8'h0F && idx_r < 8'h12) |-> txData == BLANK;
    endproperty
    a_pad: assert property (p_pad) else $error("model name not blank padded");
    property p_too_long;
        @(posedge clk) disable iff (reset)
            (state_r == S_EXEC && cmd == CMD_ECHO && rxCount_r > LEN_ECHO_MAX) |=> rc_r == RC_TOO_LONG;
    endproperty
    a_too_long: assert property (p_too_long) else $error("overlong echo not flagged");
endmodule

// ===== test/host_link_model.sv
// Purpose: host side of the command link, sends one frame and gathers the answer
// Assumes: the handler takes a char on the rising edge that sees rxValid and rxReady
// Notes: every wait is bounded; a wait that runs out raises hung for the bench
`timescale 1ns/1ps
module host_link_model (
    // clock
    input wire logic clk,
    // command characters towards the handler
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxLast,
    input wire logic rxReady,
    // response characters from the handler
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    output logic txReady
);
    logic [7:0] resp[$];
    logic hung = 1'b0;

    // idle levels before the first frame
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        rxLast = 1'b0;
        txReady = 1'b0;
    end

    // frame content is the caller's: printable bytes, any length including overlong frames
    task automatic run(input string f, input int slow);
        int n;
        logic done;
        resp.delete();
        for (int i = 0; i < f.len(); i++) begin
            @(negedge clk);
            rxValid = 1'b1;
            rxData = f[i];
            rxLast = (i == f.len() - 1);
            n = 0;
            // hold the char until a rising edge sees the handler ready
            while (1) begin
                @(posedge clk);
                if (rxReady === 1'b1 || n > 60) break;
                n++;
            end
            if (n > 60) hung = 1'b1;
        end
        @(negedge clk);
        rxValid = 1'b0;
        rxLast = 1'b0;
        rxData = ~rxData; // released line shows no stale character
        done = 1'b0;
        // slow mode stalls the sink on two cycles out of three
        for (int c = 0; c < 3000 && !done; c++) begin
            txReady = (slow == 0) || (c % 3 == 0);
            @(posedge clk);
            if (txValid === 1'b1 && txReady) begin
                resp.push_back(txData);
                done = (txLast === 1'b1);
            end
            @(negedge clk);
        end
        txReady = 1'b0;
        if (!done) hung = 1'b1;
    endtask
endmodule

// ===== test/panel_meter_command_handler_tb.sv
// Purpose: self-checking bench for the panel meter command handler
// Assumes: inputs change on the falling edge; the host model drives the link
// Notes: expected answers are built from the command codes, not read back
`timescale 1ns/1ps
module panel_meter_command_handler_tb;
    import meter_cmd_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic rxValid, rxLast, rxReady, txValid, txLast, txReady;
    logic [7:0] rxData, txData, relatedInfo;
    logic [1:0] initLockout = 2'h0;
    logic nvmFault = 1'b0;
    logic [3:0] cause = 4'h0;
    logic areaSecond, protectLevel, writeEnable;
    int num_errors = 0;
    int samples_checked = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    panel_meter_command_handler u_panel_meter_command_handler (.clk(clk), .reset(reset),
        .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxReady(rxReady),
        .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
        .initLockout(initLockout), .nvmFault(nvmFault), .measureSuspended(cause[0]),
        .noMeasuredValue(cause[1]), .inputAnomaly(cause[2]), .displayRangeOver(cause[3]),
        .relatedInfo(relatedInfo), .areaSecond(areaSecond), .protectLevel(protectLevel),
        .writeEnable(writeEnable));

    host_link_model u_host_link_model (.clk(clk), .rxValid(rxValid), .rxData(rxData),
        .rxLast(rxLast), .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txLast(txLast), .txReady(txReady));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // send a frame and compare the whole answer, length first
    task automatic xact(input string f, input int slow, input string exp);
        u_host_link_model.run(f, slow);
        if (u_host_link_model.hung) begin
            num_errors++;
            report_and_stop();
        end
        check(8'(u_host_link_model.resp.size()), 8'(exp.len()));
        for (int i = 0; i < exp.len() && i < u_host_link_model.resp.size(); i++) begin
            check(u_host_link_model.resp[i], exp[i]);
        end
    endtask

    // reset held five cycles, mode outputs all cleared afterwards
    task automatic t_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        check({7'h0, areaSecond}, 8'h00);
        check({5'h0, protectLevel, writeEnable, areaSecond}, 8'h00);
    endtask

    // area and protect moves against write permission, lockout and area
    task automatic t_moves();
        xact("30050700", 0, "30052203");
        check({7'h0, areaSecond}, 8'h00);
        xact("30050800", 0, "30052203");
        check({7'h0, protectLevel}, 8'h00);
        xact("30050001", 0, "30050000");
        check({7'h0, writeEnable}, 8'h01);
        initLockout = 2'h2;
        xact("30050700", 1, "30052203");
        check({7'h0, areaSecond}, 8'h00);
        initLockout = 2'h1;
        xact("30050800", 0, "30050000");
        check({7'h0, protectLevel}, 8'h01);
        xact("30050700", 0, "30050000");
        check({7'h0, areaSecond}, 8'h01);
        xact("30050700", 0, "30050000");
        check({7'h0, areaSecond}, 8'h01);
        xact("30050800", 0, "30052203");
        check({7'h0, protectLevel}, 8'h00);
        // overlong instruction, then writing switched off again
        xact("300500010", 0, "30051001");
        xact("30050000", 0, "30050000");
        check({7'h0, writeEnable}, 8'h00);
        xact("30050700", 0, "30052203");
        check({7'h0, areaSecond}, 8'h01);
        // unknown request code answers with the unsupported code
        xact("9999", 0, "99990401");
    endtask

    // attribute read: padded name, fixed buffer size, error codes
    task automatic t_attr();
        string e;
        e = "05030000";
        for (int i = 0; i < 10; i++) begin
            e = $sformatf("%s%c", e, (i < MODEL_LEN) ? MODEL_NAME[79-8*i -: 8] : 8'h20);
        end
        xact("0503", 1, {e, "0068"});
        xact("05030", 0, "05031001");
        nvmFault = 1'b1;
        xact("0503", 0, "05032203");
        xact("0601", 0, "06012203");
        nvmFault = 1'b0;
    endtask

    // status read for every cause, related info unknown in the second area
    task automatic t_status(input string info);
        xact("0601", 0, {"060100000", "0", info});
        for (int k = 0; k < 4; k++) begin
            cause = 4'h1 << k;
            xact("0601", 0, {"060100000", "1", info});
        end
        cause = 4'h0;
        xact("06010", 0, "06011001");
    endtask

    // version read and echoback at full length with a stalling sink
    task automatic t_ver_echo();
        string p;
        xact("0101C00000000001", 0, "0101000000000100");
        xact("0101C000000000010", 0, "01011001");
        p = "";
        for (int i = 0; i < 87; i++) p = $sformatf("%s%c", p, 8'h21 + i);
        xact({"0801", p}, 1, {"08010000", p});
        xact("0801", 0, "08010000");
        xact({"0801", p, "A"}, 0, "08011001");
    endtask

    // main sequence
    initial begin
        relatedInfo = 8'h3C;
        t_reset();
        t_status("3C");
        t_moves();
        t_status("FF");
        t_attr();
        t_ver_echo();
        t_reset();
        t_attr();
        report_and_stop();
    end
endmodule
